// [core/dsg_static_gain_curve.sv]
`timescale 1ns/1ps
`default_nettype none
module dsg_static_gain_curve
  import dsg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic level_valid,
  input wire logic signed [15:0] level_in,
  output logic signed [15:0] target_level,
  output logic signed [15:0] target_gain,
  output logic [1:0] region,
  output logic gain_valid,
  output logic signed [15:0] zero_db_output_level
);

  // ***********************************************
  // helper functions
  // ***********************************************

  // level of a code on a linear dB ladder
  function automatic logic signed [EXT_W-1:0] ladder(
    input logic signed [15:0] base,
    input logic signed [15:0] step,
    input logic [5:0] code
  );
    logic signed [EXT_W-1:0] prod;
    logic signed [EXT_W-1:0] code_ext;
    // zero-extend first so a high code is never read as negative
    code_ext = EXT_W'($signed({1'b0, code}));
    prod = EXT_W'(step) * code_ext;
    ladder = EXT_W'(base) - prod;
  endfunction

  // compression: shift right by code, zero slope gives nothing
  function automatic logic signed [EXT_W-1:0] compress(
    input logic signed [EXT_W-1:0] diff,
    input logic [2:0] code,
    input logic [2:0] zero_code
  );
    if (code >= zero_code) begin
      compress = '0; // flat output, infinite compression
    end else begin
      compress = diff >>> code; // 1, 1/2, 1/4 ...
    end
  endfunction

  // reserved knee codes stop at the last legal step
  function automatic logic [5:0] clamp_code(
    input logic [5:0] code,
    input logic [5:0] max_code
  );
    if (code > max_code) begin
      clamp_code = max_code;
    end else begin
      clamp_code = code;
    end
  endfunction

  // ***********************************************
  // control registers
  // ***********************************************
  logic gate_enable_ff, nxt_gate_enable;
  logic [4:0] k2in_code_ff, nxt_k2in_code;
  logic [5:0] k1in_code_ff, nxt_k1in_code;
  logic k2out_enable_ff, nxt_k2out_enable;
  logic [4:0] k2out_code_ff, nxt_k2out_code;
  logic [4:0] k1out_code_ff, nxt_k1out_code;
  logic [2:0] upper_code_ff, nxt_upper_code;
  logic [1:0] gexp_code_ff, nxt_gexp_code;
  logic [2:0] lower_code_ff, nxt_lower_code;
  logic [15:0] reg_rdata_ff, nxt_reg_rdata;
  logic reg_rvalid_ff, nxt_reg_rvalid;

  // register writes and read mux; unmapped addresses read zero
  always_comb begin
    nxt_gate_enable = gate_enable_ff;
    nxt_k2in_code = k2in_code_ff;
    nxt_k1in_code = k1in_code_ff;
    nxt_k2out_enable = k2out_enable_ff;
    nxt_k2out_code = k2out_code_ff;
    nxt_k1out_code = k1out_code_ff;
    nxt_upper_code = upper_code_ff;
    nxt_gexp_code = gexp_code_ff;
    nxt_lower_code = lower_code_ff;
    nxt_reg_rdata = reg_rdata_ff;
    nxt_reg_rvalid = reg_rd;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CONTROL_ONE: begin
          nxt_gate_enable = reg_wdata[GATE_ENABLE_BIT];
        end
        ADDR_KNEE_INPUTS: begin
          nxt_k2in_code = reg_wdata[K2IN_MSB:K2IN_LSB];
          nxt_k1in_code = reg_wdata[K1IN_MSB:K1IN_LSB];
        end
        ADDR_KNEE_OUTPUTS: begin
          nxt_k2out_enable = reg_wdata[K2OUT_ENABLE_BIT];
          nxt_k2out_code = reg_wdata[K2OUT_MSB:K2OUT_LSB];
          nxt_k1out_code = reg_wdata[K1OUT_MSB:K1OUT_LSB];
          nxt_upper_code = reg_wdata[UPPER_MSB:UPPER_LSB];
        end
        ADDR_GATE_LOWER: begin
          nxt_gexp_code = reg_wdata[GEXP_MSB:GEXP_LSB];
          nxt_lower_code = reg_wdata[LOWER_MSB:LOWER_LSB];
        end
        default: begin
        end
      endcase
    end
    // reads see the stored codes, so a same-cycle write shows up next time
    if (reg_rd) begin
      nxt_reg_rdata = '0;
      case (reg_addr)
        ADDR_CONTROL_ONE: begin
          nxt_reg_rdata[GATE_ENABLE_BIT] = gate_enable_ff;
        end
        ADDR_KNEE_INPUTS: begin
          nxt_reg_rdata[K2IN_MSB:K2IN_LSB] = k2in_code_ff;
          nxt_reg_rdata[K1IN_MSB:K1IN_LSB] = k1in_code_ff;
        end
        ADDR_KNEE_OUTPUTS: begin
          nxt_reg_rdata[K2OUT_ENABLE_BIT] = k2out_enable_ff;
          nxt_reg_rdata[K2OUT_MSB:K2OUT_LSB] = k2out_code_ff;
          nxt_reg_rdata[K1OUT_MSB:K1OUT_LSB] = k1out_code_ff;
          nxt_reg_rdata[UPPER_MSB:UPPER_LSB] = upper_code_ff;
        end
        ADDR_GATE_LOWER: begin
          nxt_reg_rdata[GEXP_MSB:GEXP_LSB] = gexp_code_ff;
          nxt_reg_rdata[LOWER_MSB:LOWER_LSB] = lower_code_ff;
        end
        default: begin
          nxt_reg_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gate_enable_ff <= RST_CONTROL_ONE[GATE_ENABLE_BIT];
      k2in_code_ff <= RST_KNEE_INPUTS[K2IN_MSB:K2IN_LSB];
      k1in_code_ff <= RST_KNEE_INPUTS[K1IN_MSB:K1IN_LSB];
      k2out_enable_ff <= RST_KNEE_OUTPUTS[K2OUT_ENABLE_BIT];
      k2out_code_ff <= RST_KNEE_OUTPUTS[K2OUT_MSB:K2OUT_LSB];
      k1out_code_ff <= RST_KNEE_OUTPUTS[K1OUT_MSB:K1OUT_LSB];
      upper_code_ff <= RST_KNEE_OUTPUTS[UPPER_MSB:UPPER_LSB];
      gexp_code_ff <= RST_GATE_LOWER[GEXP_MSB:GEXP_LSB];
      lower_code_ff <= RST_GATE_LOWER[LOWER_MSB:LOWER_LSB];
      reg_rdata_ff <= '0;
      reg_rvalid_ff <= 1'b0;
    end else begin
      gate_enable_ff <= nxt_gate_enable;
      k2in_code_ff <= nxt_k2in_code;
      k1in_code_ff <= nxt_k1in_code;
      k2out_enable_ff <= nxt_k2out_enable;
      k2out_code_ff <= nxt_k2out_code;
      k1out_code_ff <= nxt_k1out_code;
      upper_code_ff <= nxt_upper_code;
      gexp_code_ff <= nxt_gexp_code;
      lower_code_ff <= nxt_lower_code;
      reg_rdata_ff <= nxt_reg_rdata;
      reg_rvalid_ff <= nxt_reg_rvalid;
    end
  end

  // ***********************************************
  // knee decode
  // ***********************************************
  logic [5:0] k1in_eff;
  logic [4:0] k1out_eff;
  logic signed [EXT_W-1:0] k1_in, k1_out, k2_in, k2_out_prog;

  // reserved codes clamp to the last legal step rather than wrapping
  always_comb begin
    k1in_eff = clamp_code(k1in_code_ff, K1IN_MAX_CODE);
    k1out_eff = 5'(clamp_code({1'b0, k1out_code_ff}, {1'b0, K1OUT_MAX_CODE}));
    k1_in = ladder('0, STEP_FINE, k1in_eff);
    k1_out = ladder('0, STEP_FINE, {1'b0, k1out_eff});
    k2_in = ladder(KNEE2_IN_BASE, STEP_COARSE, {1'b0, k2in_code_ff});
    k2_out_prog = ladder(KNEE2_OUT_BASE, STEP_COARSE, {1'b0, k2out_code_ff});
  end

  // ***********************************************
  // static curve
  // ***********************************************
  logic signed [EXT_W-1:0] x_ext, y_upper, y_lower, k2_on_lower, k2_out, y_gate, y_sel, y_zero;
  logic signed [EXT_W-1:0] gain_ext;
  dsg_region_t region_sel;

  always_comb begin
    x_ext = EXT_W'(level_in);
    y_upper = k1_out + compress(x_ext - k1_in, upper_code_ff, UPPER_ZERO_CODE);
    y_lower = k1_out + compress(x_ext - k1_in, lower_code_ff, LOWER_ZERO_CODE);
    // lower line evaluated at the second knee keeps the curve continuous
    k2_on_lower = k1_out + compress(k2_in - k1_in, lower_code_ff, LOWER_ZERO_CODE);
    // enabled output level gives a vertical step at the second knee
    k2_out = k2out_enable_ff ? k2_out_prog : k2_on_lower;
    y_gate = k2_out + ((x_ext - k2_in) <<< gexp_code_ff); // slopes 1, 2, 4, 8
    y_zero = k1_out - compress(k1_in, upper_code_ff, UPPER_ZERO_CODE);
    // upper line owns the knee point itself; gate sits below both knees
    if (x_ext >= k1_in) begin
      y_sel = y_upper;
      region_sel = DSG_REGION_UPPER;
    end else if (gate_enable_ff && (x_ext < k2_in)) begin
      y_sel = y_gate;
      region_sel = DSG_REGION_GATE;
    end else begin
      y_sel = y_lower; // gate off: lower line all the way down
      region_sel = DSG_REGION_LOWER;
    end
    gain_ext = y_sel - x_ext;
  end

  // saturate to the 16-bit level range; deep gate slopes can run far below
  function automatic logic signed [15:0] sat16(input logic signed [EXT_W-1:0] v);
    logic signed [EXT_W-1:0] top;
    logic signed [EXT_W-1:0] bottom;
    // widen both limits as signed values so the floor stays negative
    top = EXT_W'(16'sh7fff);
    bottom = EXT_W'(16'sh8000);
    if (v > top) begin
      sat16 = 16'sh7fff;
    end else if (v < bottom) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // ***********************************************
  // output stage
  // ***********************************************
  logic signed [15:0] target_level_ff, nxt_target_level;
  logic signed [15:0] target_gain_ff, nxt_target_gain;
  logic [1:0] region_ff, nxt_region;
  logic gain_valid_ff, nxt_gain_valid;
  logic signed [15:0] zero_db_ff, nxt_zero_db;

  // results update only with a fresh level sample
  always_comb begin
    nxt_target_level = target_level_ff;
    nxt_target_gain = target_gain_ff;
    nxt_region = region_ff;
    nxt_gain_valid = level_valid;
    // zero-dB level follows the registers every cycle, no sample needed
    nxt_zero_db = sat16(y_zero);
    if (level_valid) begin
      nxt_target_level = sat16(y_sel);
      nxt_target_gain = sat16(gain_ext);
      nxt_region = region_sel;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      target_level_ff <= '0;
      target_gain_ff <= '0;
      region_ff <= DSG_REGION_UPPER;
      gain_valid_ff <= 1'b0;
      zero_db_ff <= '0;
    end else begin
      target_level_ff <= nxt_target_level;
      target_gain_ff <= nxt_target_gain;
      region_ff <= nxt_region;
      gain_valid_ff <= nxt_gain_valid;
      zero_db_ff <= nxt_zero_db;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;
  assign target_level = target_level_ff;
  assign target_gain = target_gain_ff;
  assign region = region_ff;
  assign gain_valid = gain_valid_ff;
  assign zero_db_output_level = zero_db_ff;

endmodule
`default_nettype wire

// [core/dsg_pkg.sv]
package dsg_pkg;
  // ***********************************************
  // level format
  // ***********************************************
  // signed levels in dB, one lsb = 1/64 dB
  localparam int LVL_W = 16;
  localparam int EXT_W = 20;
  localparam logic signed [15:0] STEP_FINE = 16'sh0030; // 0.75 dB
  localparam logic signed [15:0] STEP_COARSE = 16'sh0060; // 1.5 dB
  localparam logic signed [15:0] KNEE2_IN_BASE = -16'sh0900; // -36 dB
  localparam logic signed [15:0] KNEE2_OUT_BASE = -16'sh0780; // -30 dB

  // ***********************************************
  // register addresses
  // ***********************************************
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h1d;
  localparam logic [7:0] ADDR_KNEE_INPUTS = 8'h20;
  localparam logic [7:0] ADDR_KNEE_OUTPUTS = 8'h21;
  localparam logic [7:0] ADDR_GATE_LOWER = 8'h23;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int GATE_ENABLE_BIT = 8;
  localparam int K2IN_LSB = 8;
  localparam int K2IN_MSB = 12;
  localparam int K1IN_LSB = 2;
  localparam int K1IN_MSB = 7;
  localparam int K2OUT_ENABLE_BIT = 13;
  localparam int K2OUT_LSB = 8;
  localparam int K2OUT_MSB = 12;
  localparam int K1OUT_LSB = 3;
  localparam int K1OUT_MSB = 7;
  localparam int UPPER_LSB = 0;
  localparam int UPPER_MSB = 2;
  localparam int GEXP_LSB = 8;
  localparam int GEXP_MSB = 9;
  localparam int LOWER_LSB = 5;
  localparam int LOWER_MSB = 7;

  // ***********************************************
  // reset values and code limits
  // ***********************************************
  localparam logic [15:0] RST_CONTROL_ONE = 16'h0000;
  localparam logic [15:0] RST_KNEE_INPUTS = 16'h0000;
  localparam logic [15:0] RST_KNEE_OUTPUTS = 16'h0003;
  localparam logic [15:0] RST_GATE_LOWER = 16'h0000;
  localparam logic [5:0] K1IN_MAX_CODE = 6'h3c;
  localparam logic [4:0] K1OUT_MAX_CODE = 5'h1e;
  localparam logic [2:0] UPPER_ZERO_CODE = 3'h5;
  localparam logic [2:0] LOWER_ZERO_CODE = 3'h4;

  // curve region of the last result
  typedef enum logic [1:0] {
    DSG_REGION_UPPER = 2'b00,
    DSG_REGION_LOWER = 2'b01,
    DSG_REGION_GATE = 2'b10
  } dsg_region_t;
endpackage

// [verif/dsg_static_gain_curve_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module dsg_props
  import dsg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic level_valid,
  input wire logic signed [15:0] level_in,
  input wire logic signed [15:0] target_level,
  input wire logic signed [15:0] target_gain,
  input wire logic [1:0] region,
  input wire logic gain_valid
);
  // ***********************************************
  // sample path and register port timing
  // ***********************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // a sample taken, and its one-cycle answer
  sequence s_take;
    level_valid;
  endsequence
  sequence s_answer;
    gain_valid;
  endsequence
  a_gain_pulse: assert property (s_take |=> s_answer)
    else $error("gain_valid missing after level_valid");
  a_gain_quiet: assert property (!level_valid |=> !gain_valid)
    else $error("gain_valid without a sample");
  a_gain_diff: assert property (level_valid |=> target_gain == target_level - $past(level_in))
    else $error("target_gain is not level minus input");
  // non-negative input is always at or above the first knee
  a_upper_above: assert property (level_valid && !level_in[15] |=> region == DSG_REGION_UPPER)
    else $error("non-negative input left the upper region");
  a_region_legal: assert property (region != 2'b11)
    else $error("region code 11 seen");
  // gate region is only reachable below the shallowest second knee
  a_gate_depth: assert property (gain_valid && region == DSG_REGION_GATE |->
    $past(level_in) < KNEE2_IN_BASE)
    else $error("gate region for an input above the second knee");
  a_result_hold: assert property (!level_valid |=> $stable(target_level) && $stable(region))
    else $error("result changed without a sample");
  a_rvalid_pulse: assert property (reg_rd |=> reg_rvalid)
    else $error("reg_rvalid missing after reg_rd");
  a_rvalid_quiet: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata))
    else $error("read answer without a read");
endmodule
bind dsg_static_gain_curve dsg_props dsg_props_i (.clock(clock), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .level_valid(level_valid), .level_in(level_in), .target_level(target_level),
  .target_gain(target_gain), .region(region), .gain_valid(gain_valid));
`default_nettype wire

// [verif/tb_drc_static_gain_curve.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_drc_static_gain_curve;
  import dsg_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic level_valid = 1'b0;
  logic signed [15:0] level_in = 16'sh0000;
  logic signed [15:0] target_level, target_gain, zero_db_output_level;
  logic [1:0] region;
  logic gain_valid;
  int err_total = 0;
  int cmp_count = 0;
  // field copies, defaults match reset
  int f_ge = 0, f_k2i = 0, f_k1i = 0, f_ke = 0, f_k2o = 0, f_k1o = 0, f_hi = 3, f_ex = 0;
  int f_lo = 0;
  // ***********************************************
  // clock and design
  // ***********************************************
  always #2.5 clock = ~clock;
  dsg_static_gain_curve dsg_static_gain_curve_i (.clock(clock), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .level_valid(level_valid),
    .level_in(level_in), .target_level(target_level), .target_gain(target_gain),
    .region(region), .gain_valid(gain_valid), .zero_db_output_level(zero_db_output_level));
  // ***********************************************
  // helpers
  // ***********************************************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  // expected curve point; slope codes at or past the zero code give a flat line
  function automatic int model(input int x, output logic [1:0] rg);
    int a, b, k2, y;
    a = -48 * f_k1i;
    b = -48 * f_k1o;
    k2 = -2304 - 96 * f_k2i;
    rg = DSG_REGION_UPPER;
    if (x >= a) begin
      y = b + (f_hi >= 5 ? 0 : (x - a) >>> f_hi);
    end else if (f_ge != 0 && x < k2) begin
      rg = DSG_REGION_GATE;
      y = f_ke != 0 ? -1920 - 96 * f_k2o : b + (f_lo >= 4 ? 0 : (k2 - a) >>> f_lo);
      y = y + (x - k2) * (1 << f_ex);
    end else begin
      rg = DSG_REGION_LOWER;
      y = b + (f_lo >= 4 ? 0 : (x - a) >>> f_lo);
    end
    return y;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg_rvalid", 16'h0001, {15'h0000, reg_rvalid});
    chk("reg_rdata", e, reg_rdata);
  endtask
  // writes all fields from the copies, then checks the 0 dB point
  task automatic apply();
    wr(ADDR_CONTROL_ONE, 16'(f_ge << 8));
    wr(ADDR_KNEE_INPUTS, 16'((f_k2i << 8) | (f_k1i << 2)));
    wr(ADDR_KNEE_OUTPUTS, 16'((f_ke << 13) | (f_k2o << 8) | (f_k1o << 3) | f_hi));
    wr(ADDR_GATE_LOWER, 16'((f_ex << 8) | (f_lo << 5)));
    @(posedge clock);
    #1 chk("zero_db_output_level", 16'(-48 * f_k1o - (f_hi >= 5 ? 0 : (-48 * f_k1i) >>> f_hi)),
      zero_db_output_level);
  endtask
  task automatic smp(input int x);
    logic [1:0] rg;
    int y;
    y = model(x, rg);
    @(posedge clock);
    level_valid <= 1'b1;
    level_in <= 16'(x);
    @(posedge clock);
    level_valid <= 1'b0;
    #1 chk("gain_valid", 16'h0001, {15'h0000, gain_valid});
    chk("target_level", 16'(y), target_level);
    chk("target_gain", 16'(y - x), target_gain);
    chk("region", {14'h0000, rg}, {14'h0000, region});
  endtask
  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_reset();
    rd(ADDR_CONTROL_ONE, RST_CONTROL_ONE);
    rd(ADDR_KNEE_INPUTS, RST_KNEE_INPUTS);
    rd(ADDR_KNEE_OUTPUTS, RST_KNEE_OUTPUTS);
    rd(ADDR_GATE_LOWER, RST_GATE_LOWER);
    rd(8'h22, 16'h0000);
  endtask
  task automatic t_upper();
    f_k1i = 8;
    f_k1o = 4;
    for (int h = 0; h < 8; h++) begin
      f_hi = h;
      apply();
      smp(0);
      smp(-200);
    end
  endtask
  // gate fields loaded but gate off, so they must not matter
  task automatic t_lower();
    f_hi = 3;
    f_ex = 3;
    f_ke = 1;
    f_k2o = 5;
    for (int l = 0; l < 8; l++) begin
      f_lo = l;
      apply();
      smp(-3000);
    end
  endtask
  task automatic t_gate();
    f_ge = 1;
    f_lo = 1;
    for (int e = 0; e < 4; e++) begin
      for (int k = 0; k < 2; k++) begin
        f_ex = e;
        f_ke = k;
        f_k2i = e == 3 ? 31 : e;
        f_k2o = 31 - e;
        apply();
        smp(-2404 - 96 * f_k2i);
        smp(-2304 - 96 * f_k2i);
      end
    end
  endtask
  // last legal knee codes, both sides of the first knee
  task automatic t_codes();
    f_ge = 0;
    f_k1i = 60;
    f_k1o = 30;
    f_hi = 4;
    apply();
    rd(ADDR_KNEE_INPUTS, 16'((f_k2i << 8) | (60 << 2)));
    smp(-2880);
    smp(-2881);
    // reserved knee codes must act as the last legal step
    wr(ADDR_KNEE_INPUTS, 16'((f_k2i << 8) | (63 << 2)));
    wr(ADDR_KNEE_OUTPUTS, 16'((f_ke << 13) | (f_k2o << 8) | (31 << 3) | f_hi));
    smp(-2880);
    smp(-2881);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_upper();
    t_lower();
    t_gate();
    t_codes();
    final_report();
  end
  // run needs well under 2000 cycles
  initial begin
    #50000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
